// ### core/buck_cfg.svh
// Constants for the buck regulator configuration bank
`ifndef BUCK_CFG_SVH
`define BUCK_CFG_SVH
`define NUM_BUCKS 4
`define BUCK_CONFIG_ONE_BASE 8'h1D
`define BUCK_CONFIG_TWO_ADDR 8'h22
`define BUCK_CONFIG_ONE_RESET 8'h40
`define BUCK_CONFIG_TWO_RESET 8'h07
`define BUCK_CONFIG_TWO_WMASK 8'h06
`define BUCK_CONFIG_TWO_RMASK 8'h07
`define BIT_SLEW_HI 7
`define BIT_SLEW_LO 6
`define BIT_MODE_HI 5
`define BIT_MODE_LO 4
`define BIT_DISCHARGE_DIS_N 3
`define BIT_FORCED_PWM 2
`define BIT_RESERVED_ONE 1
`define BIT_FALL_DISCHARGE_DIS_N 0
`define BIT_BUCK0_SENSE 2
`define BIT_BUCK1_SENSE 1
`define MODE_LOW_POWER 2'h2
`define MODE_GROUP_LOW_POWER 2'h1
`define PWM_HOLD_US 50
`define CLK_MHZ 100
`define PWM_HOLD_CYCLES (`PWM_HOLD_US * `CLK_MHZ)
`endif

// ### core/buck_channel.sv
// One buck regulator channel: discharge, PWM and falling-ramp hold control
`timescale 1ns/1ps
`include "buck_cfg.svh"
module buck_channel
    import buck_pkg::*;
#(
    parameter int HOLD_CYCLES = `PWM_HOLD_CYCLES
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Configuration and regulator state
    input wire buck_config_one_s cfg,
    input wire buck_status_s stat,
    // Controls to the analog core
    output buck_ctrl_s ctrl
);
    ramp_state_e state;
    ramp_state_e next_state;
    logic [$clog2(HOLD_CYCLES + 1)-1:0] count;
    logic [$clog2(HOLD_CYCLES + 1)-1:0] next_count;
    buck_ctrl_s next_ctrl;
    logic fall_discharge_on;

    // Low-power mode makes the falling discharge bit act as disabled
    assign fall_discharge_on = !cfg.fall_discharge_disable_n && !stat.low_power;

    always_comb
    begin
        next_state = state;
        next_count = count;
        case (state)
            IDLE:
            begin
                if (stat.ramp_down)
                begin
                    next_state = RAMPING;
                end
            end
            RAMPING:
            begin
                if (stat.ramp_done)
                begin
                    next_state = HOLDING;
                    next_count = '0;
                end
            end
            HOLDING:
            begin
                if (stat.ramp_down)
                begin
                    next_state = RAMPING;
                end
                else if (count >= HOLD_CYCLES[$bits(count)-1:0] - 1'b1)
                begin
                    next_state = IDLE;
                end
                else
                begin
                    next_count = count + 1'b1;
                end
            end
            default:
            begin
                next_state = IDLE;
            end
        endcase
        if (!stat.enabled)
        begin
            next_state = IDLE;
        end
        next_ctrl.discharge_connect = !cfg.discharge_disable_n && !stat.enabled;
        next_ctrl.pwm_force = cfg.forced_pwm
            || (fall_discharge_on && (next_state != IDLE));
        next_ctrl.skip_allowed = !next_ctrl.pwm_force;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state <= IDLE;
            count <= '0;
            ctrl <= '0;
        end
        else
        begin
            state <= next_state;
            count <= next_count;
            ctrl <= next_ctrl;
        end
    end
endmodule : buck_channel

// ### core/buck_pkg.sv
// Types shared by the buck regulator configuration bank
package buck_pkg;
    typedef struct packed {
        logic [1:0] slew_rate;
        logic [1:0] power_mode;
        logic discharge_disable_n;
        logic forced_pwm;
        logic reserved_one;
        logic fall_discharge_disable_n;
    } buck_config_one_s;

    typedef struct packed {
        logic enabled;
        logic low_power;
        logic ramp_down;
        logic ramp_done;
    } buck_status_s;

    typedef struct packed {
        logic discharge_connect;
        logic pwm_force;
        logic skip_allowed;
    } buck_ctrl_s;

    typedef enum logic [1:0] {
        IDLE,
        RAMPING,
        HOLDING
    } ramp_state_e;
endpackage : buck_pkg

// ### core/buck_regulator_config_bits.sv
// Buck regulator configuration registers and per-channel control outputs
`timescale 1ns/1ps
`include "buck_cfg.svh"
// Summary of operation
// - Discharge resistor on when enabled bit low, off
// - Discharge bit high never connects the resistor
// - Forced PWM clear allows automatic skip switching
// - Forced PWM set holds fixed frequency always
// - Low-power mode ignores the falling discharge bit
// - Falling discharge forces PWM, held 50us after
// - Discharge disabled allows skip only without forced PWM
// - Buck zero sense gated in low power
// - Buck one sense gated in low power
// - Slew field selects one of four rates
// - Power mode code two forces low power
module buck_regulator_config_bits
    import buck_pkg::*;
#(
    parameter int NUM_BUCKS = `NUM_BUCKS,
    parameter int HOLD_CYCLES = `PWM_HOLD_CYCLES
)
(
    // Clock and global-shutdown reset
    input wire logic clk,
    input wire logic rst,
    // Register port from the serial interface, same clock
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Regulator state from the analog cores
    input wire logic [NUM_BUCKS-1:0] buck_enabled,
    input wire logic [NUM_BUCKS-1:0] group_low_power,
    input wire logic [NUM_BUCKS-1:0] buck_ramp_down,
    input wire logic [NUM_BUCKS-1:0] buck_ramp_done,
    // Controls to the analog cores
    output logic [NUM_BUCKS-1:0] buck_discharge_connect,
    output logic [NUM_BUCKS-1:0] buck_pwm_force,
    output logic [NUM_BUCKS-1:0] buck_skip_allowed,
    output logic [NUM_BUCKS*2-1:0] buck_slew_rate_sel,
    output logic [NUM_BUCKS-1:0] buck_low_power,
    output logic buck0_remote_sense_active,
    output logic buck1_remote_sense_active
);
    buck_config_one_s config_one [NUM_BUCKS];
    buck_config_one_s next_config_one [NUM_BUCKS];
    logic [7:0] buck_config_two;
    logic [7:0] next_buck_config_two;
    logic [7:0] next_reg_rdata;
    logic [NUM_BUCKS-1:0] low_power_now;
    logic [NUM_BUCKS-1:0] next_low_power;
    logic [NUM_BUCKS*2-1:0] next_slew;
    logic next_sense0;
    logic next_sense1;
    // Address decode of the register port
    logic [NUM_BUCKS-1:0] hit_one;
    logic hit_two;
    // Synchroniser stages
    logic [NUM_BUCKS-1:0] enabled_meta;
    logic [NUM_BUCKS-1:0] enabled_sync;
    logic [NUM_BUCKS-1:0] group_meta;
    logic [NUM_BUCKS-1:0] group_sync;
    logic [NUM_BUCKS-1:0] ramp_down_meta;
    logic [NUM_BUCKS-1:0] ramp_down_sync;
    logic [NUM_BUCKS-1:0] ramp_done_meta;
    logic [NUM_BUCKS-1:0] ramp_done_sync;

    // Status levels from the analog cores are asynchronous; only the second stage is read
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            enabled_meta <= '0;
            enabled_sync <= '0;
            group_meta <= '0;
            group_sync <= '0;
            ramp_down_meta <= '0;
            ramp_down_sync <= '0;
            ramp_done_meta <= '0;
            ramp_done_sync <= '0;
        end
        else
        begin
            enabled_meta <= buck_enabled;
            enabled_sync <= enabled_meta;
            group_meta <= group_low_power;
            group_sync <= group_meta;
            ramp_down_meta <= buck_ramp_down;
            ramp_down_sync <= ramp_down_meta;
            ramp_done_meta <= buck_ramp_done;
            ramp_done_sync <= ramp_done_meta;
        end
    end

    assign hit_two = (reg_addr == `BUCK_CONFIG_TWO_ADDR);

    genvar g;
    generate
        for (g = 0; g < NUM_BUCKS; g++)
        begin : gen_buck
            buck_status_s stat;
            buck_ctrl_s ctrl;
            assign hit_one[g] = (reg_addr == `BUCK_CONFIG_ONE_BASE + 8'(g));
            // Code two forces low power; group mode follows the global signal
            assign low_power_now[g] = (config_one[g].power_mode == `MODE_LOW_POWER)
                || (config_one[g].power_mode == `MODE_GROUP_LOW_POWER && group_sync[g]);
            assign stat = '{
                enabled: enabled_sync[g],
                low_power: low_power_now[g],
                ramp_down: ramp_down_sync[g],
                ramp_done: ramp_done_sync[g]
            };
            always_comb
            begin
                next_config_one[g] = config_one[g];
                if (reg_wr && hit_one[g])
                begin
                    next_config_one[g] = reg_wdata;
                end
            end
            buck_channel #(
                .HOLD_CYCLES(HOLD_CYCLES)
            ) u_channel (
                .clk(clk),
                .rst(rst),
                .cfg(config_one[g]),
                .stat(stat),
                .ctrl(ctrl)
            );
            assign buck_discharge_connect[g] = ctrl.discharge_connect;
            assign buck_pwm_force[g] = ctrl.pwm_force;
            assign buck_skip_allowed[g] = ctrl.skip_allowed;
            assign next_slew[g*2 +: 2] = config_one[g].slew_rate;
            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                begin
                    config_one[g] <= `BUCK_CONFIG_ONE_RESET;
                end
                else
                begin
                    config_one[g] <= next_config_one[g];
                end
            end
        end
    endgenerate

    // Config two: only the sense enables take writes
    always_comb
    begin
        next_buck_config_two = buck_config_two;
        if (reg_wr && hit_two)
        begin
            // Reserved bits keep their values; host is expected to write zeros
            next_buck_config_two = (reg_wdata & `BUCK_CONFIG_TWO_WMASK)
                | (buck_config_two & ~`BUCK_CONFIG_TWO_WMASK);
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            buck_config_two <= `BUCK_CONFIG_TWO_RESET;
        end
        else
        begin
            buck_config_two <= next_buck_config_two;
        end
    end

    // Read data follows the address one cycle later
    always_comb
    begin
        next_reg_rdata = 8'h00;
        for (int i = 0; i < NUM_BUCKS; i++)
        begin
            // Bit one is stored as written; host keeps it zero
            if (hit_one[i])
            begin
                next_reg_rdata = config_one[i];
            end
        end
        if (hit_two)
        begin
            next_reg_rdata = buck_config_two & `BUCK_CONFIG_TWO_RMASK;
        end
    end

    // Sense enables are gated by low power without touching the stored bits
    always_comb
    begin
        next_low_power = low_power_now;
        // Sensing resumes by itself when low power ends
        next_sense0 = buck_config_two[`BIT_BUCK0_SENSE] && !low_power_now[0];
        next_sense1 = buck_config_two[`BIT_BUCK1_SENSE] && !low_power_now[1];
    end

    // Outputs leave straight from flip-flops
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            reg_rdata <= 8'h00;
            buck_low_power <= '0;
            buck_slew_rate_sel <= '0;
            buck0_remote_sense_active <= 1'b0;
            buck1_remote_sense_active <= 1'b0;
        end
        else
        begin
            reg_rdata <= next_reg_rdata;
            buck_low_power <= next_low_power;
            buck_slew_rate_sel <= next_slew;
            buck0_remote_sense_active <= next_sense0;
            buck1_remote_sense_active <= next_sense1;
        end
    end
endmodule : buck_regulator_config_bits

// ### tb/buck_props.sv
// Checker for the buck configuration bank
`timescale 1ns/1ps
module buck_props
#(
    parameter int NUM_BUCKS = 4,
    parameter int HOLD_CYCLES = 20
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // Regulator state and controls
    input wire logic [NUM_BUCKS-1:0] buck_enabled,
    input wire logic [NUM_BUCKS-1:0] buck_ramp_done,
    input wire logic [NUM_BUCKS-1:0] buck_discharge_connect,
    input wire logic [NUM_BUCKS-1:0] buck_pwm_force,
    input wire logic [NUM_BUCKS-1:0] buck_skip_allowed,
    input wire logic [NUM_BUCKS*2-1:0] buck_slew_rate_sel,
    input wire logic [NUM_BUCKS-1:0] buck_low_power,
    input wire logic buck0_remote_sense_active,
    input wire logic buck1_remote_sense_active
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    disch_on_a: assert property ((buck_enabled & $past(buck_enabled) & $past(buck_enabled, 2)
        & $past(buck_enabled, 3) & buck_discharge_connect) == '0) else $error("discharge while on");
    skip_inv_a: assert property (!$past(rst) && !$past(rst, 2) && !$past(rst, 3)
        |-> buck_skip_allowed == ~buck_pwm_force) else $error("skip not inverse of pwm");
    sense0_a: assert property (buck_low_power[0] && $past(buck_low_power[0])
        |-> !buck0_remote_sense_active) else $error("sense0 in low power");
    sense1_a: assert property (buck_low_power[1] && $past(buck_low_power[1])
        |-> !buck1_remote_sense_active) else $error("sense1 in low power");
    cfg2_read_a: assert property (reg_wr && reg_addr == 8'h22 ##1 reg_addr == 8'h22
        |=> reg_rdata == (($past(reg_wdata, 2) & 8'h06) | 8'h01)) else $error("config two readback");
    slew_sel_a: assert property (reg_wr && reg_addr == 8'h1D
        |-> ##2 buck_slew_rate_sel[1:0] == $past(reg_wdata[7:6], 2)) else $error("slew select");
    low_power_a: assert property (reg_wr && reg_addr == 8'h1D && reg_wdata[5:4] == 2'h2
        |-> ##2 buck_low_power[0]) else $error("low power mode");
    pwm_hold_a: assert property ($fell(buck_ramp_done[0]) && buck_pwm_force[0] && buck_enabled[0]
        |-> buck_pwm_force[0] [*8]) else $error("pwm hold short");
    cover property (buck_discharge_connect[0]);
    cover property ($fell(buck_ramp_done[0]) && buck_pwm_force[0]);
    cover property (buck_low_power[1] && !buck1_remote_sense_active);
endmodule : buck_props
bind buck_regulator_config_bits buck_props #(.NUM_BUCKS(NUM_BUCKS), .HOLD_CYCLES(HOLD_CYCLES)) u_props (.*);

// ### tb/host_model.sv
// Host model issuing register writes and read selects
`timescale 1ns/1ps
module host_model
(
    // Clock
    input wire logic clk,
    // Register port toward the bank
    output logic reg_wr,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata
);
    initial
    begin
        reg_wr = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = (a == 8'h22) ? (d & 8'h06) : (d & 8'hFD);
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_wdata = ~reg_wdata;
    endtask : wr
    task automatic sel(input logic [7:0] a);
        @(negedge clk);
        reg_addr = a;
    endtask : sel
endmodule : host_model

// ### tb/tb.sv
// Self-checking testbench for the buck configuration bank
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin bad_count++; $display("Error %0t: got %h want %h", $time, a, e); end end
module tb;
    logic clk, rst, reg_wr, s0, s1;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, slew;
    logic [3:0] en, glp, rdn, rdone, dis, pwm, skip, lp;
    int bad_count, total_checks;
    host_model hst (.clk(clk), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
    buck_regulator_config_bits #(.HOLD_CYCLES(20)) DUT (.clk(clk), .rst(rst), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .buck_enabled(en),
        .group_low_power(glp), .buck_ramp_down(rdn), .buck_ramp_done(rdone), .buck_discharge_connect(dis),
        .buck_pwm_force(pwm), .buck_skip_allowed(skip), .buck_slew_rate_sel(slew), .buck_low_power(lp),
        .buck0_remote_sense_active(s0), .buck1_remote_sense_active(s1));
    always #5 clk = ~clk;
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask : step
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        hst.sel(a);
        step(1);
        `CHK(reg_rdata, e)
    endtask : rd
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    task automatic t_basic;
        rd(8'h22, 8'h07);
        rd(8'h1D, 8'h40);
        `CHK(slew, 8'h55)
        hst.wr(8'h1D, 8'h40);
        step(3);
        `CHK(dis[0], 1'b1)
        en[0] = 1'b1;
        step(3);
        `CHK(dis[0], 1'b0)
        en[0] = 1'b0;
        hst.wr(8'h1D, 8'h48);
        step(3);
        `CHK(dis[0], 1'b0)
        en[0] = 1'b1;
        hst.wr(8'h1D, 8'h44);
        step(3);
        `CHK({pwm[0], skip[0]}, 2'b10)
        hst.wr(8'h1D, 8'h40);
        step(3);
        `CHK({pwm[0], skip[0]}, 2'b01)
        $display("done: basic");
    endtask : t_basic
    task automatic t_ramp;
        hst.wr(8'h1D, 8'h70);
        rdn[0] = 1'b1;
        step(3);
        `CHK(pwm[0], 1'b1)
        rdn[0] = 1'b0;
        rdone[0] = 1'b1;
        step(1);
        rdone[0] = 1'b0;
        step(15);
        `CHK(pwm[0], 1'b1)
        step(10);
        `CHK(pwm[0], 1'b0)
        hst.wr(8'h1D, 8'h71);
        rdn[0] = 1'b1;
        step(3);
        `CHK(pwm[0], 1'b0)
        rdn[0] = 1'b0;
        $display("done: ramp");
    endtask : t_ramp
    task automatic t_low;
        en = 4'h3;
        for (int b = 0; b < 2; b++)
        begin
            hst.wr(8'h1D + 8'(b), 8'h60);
            rdn[b] = 1'b1;
            step(3);
            `CHK({pwm[b], lp[b], (b ? s1 : s0)}, 3'b010)
            rdn[b] = 1'b0;
            rd(8'h22, 8'h07);
            hst.wr(8'h1D + 8'(b), 8'h70);
            step(3);
            `CHK((b ? s1 : s0), 1'b1)
        end
        hst.wr(8'h1D, 8'h50);
        glp[0] = 1'b1;
        step(3);
        `CHK(lp[0], 1'b1)
        hst.wr(8'h22, 8'h00);
        rd(8'h22, 8'h01);
        `CHK({s0, s1}, 2'b00)
        rd(8'h21, 8'h00);
        $display("done: low power");
    endtask : t_low
    initial
    begin
        {clk, rst, en, glp, rdn, rdone, bad_count, total_checks} = '0;
        rst = 1'b1;
        step(5);
        rst = 1'b0;
        t_basic();
        t_ramp();
        t_low();
        give_verdict();
    end
    initial
    begin
        #20000;
        bad_count++;
        give_verdict();
    end
endmodule : tb
